// ==== core/hfc_top.v ====
// heating and acquisition-fault controller, top level
// inputs are synchronous to sys_clk_in; temperatures signed in 0.1 degC
//
// Summary of operation
// R1 - short averaging: fault after 10 s without value
// R2 - long averaging: fault when buffer under half
// R3 - fault forces analog outputs to min/max
// R4 - fault requests error telegram and status bit
// R5 - heating modes 0..6; mode 0 off
// R6 - criterion: 10 s continuous failure and voltage
// R7 - mode 1 both heaters on cold or fault
// R8 - mode 1 arm off: 10 s, warm, no criterion
// R9 - mode 1 transducer holds one hour then off
// R10 - mode 2 ramps 125 s, then stays on
// R11 - mode 3 arm switch-on thresholds
// R12 - modes 3/4 arm off above 7/8 degC
// R13 - mode 3 transducer switch-on thresholds
// R14 - mode 3 transducer hold start condition
// R15 - mode 4 arm switch-on thresholds
// R16 - mode 4 transducer switch-on thresholds
// R17 - mode 4 transducer hold start condition
// R18 - mode 5 arm on/off thresholds
// R19 - mode 5 transducer switch-on thresholds
// R20 - mode 5 transducer hold start condition
// R21 - mode 6 full at once; voltage gates all
// R22 - arm heating off at 30 degC
// R23 - renewed switch-on restarts the hold timer
`timescale 1ns/1ps
`default_nettype none
`include "hfc_consts.vh"
module hfc_top #(
    parameter [31:0] SEC_TICKS = `HFC_SEC_TICKS,
    parameter [11:0] HOLD_SECS = `HFC_HOLD_SECS
) (
    // clock and reset
    input  wire        sys_clk_in,
    input  wire        nrst_in,
    // acquisition
    input  wire        new_value_in,
    input  wire [15:0] buffer_count_in,
    input  wire [15:0] averaging_time_setting_in,
    // analog output configuration
    input  wire        analog_enable_in,
    input  wire        error_output_level_select_in,
    // heating configuration
    input  wire [2:0]  heating_mode_select_in,
    input  wire [15:0] virtual_temp_low_limit_in,
    input  wire [15:0] virtual_temp_high_limit_in,
    input  wire [15:0] heating_voltage_threshold_in,
    // measurements
    input  wire [15:0] virtual_temp_in,
    input  wire [15:0] base_temperature_in,
    input  wire [15:0] arm_temp_in,
    input  wire [15:0] supply_voltage_in,
    // fault outputs
    output reg         fault_out,
    output reg         analog_force_out,
    output reg         analog_force_max_out,
    output reg         error_telegram_req_out,
    output reg         status_error_out,
    // heating outputs
    output reg         criterion_out,
    output reg         arm_heat_out,
    output reg  [7:0]  arm_heat_level_out,
    output reg         transducer_heat_out,
    output reg         heating_on_out
);
    function lt;
        input [15:0] a;
        input [15:0] b;
        begin
            lt = $signed(a) < $signed(b);
        end
    endfunction

    // codes above 6 are unused and switch heating off like mode 0
    function heat_off;
        input [2:0] m;
        begin
            heat_off = (m == `HFC_MODE_OFF) || (m > `HFC_MODE_FULL);
        end
    endfunction

    // reset release through two flops
    reg rst_meta;
    reg rst_sync_n;
    always @(posedge sys_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rst_meta   <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_n <= rst_meta;
        end
    end
    wire rst = ~rst_sync_n;

    wire sec_tick;
    hfc_tick #(.DIV(SEC_TICKS)) u_tick (
        .clk_in   (sys_clk_in),
        .rst_in   (rst),
        .tick_out (sec_tick)
    );

    // fault detection
    reg  [7:0]  no_value_secs;
    reg  [7:0]  fail_secs;
    reg         fault;
    wire        short_avg = averaging_time_setting_in < `HFC_AVG_10S;
    // count*20 < av(0.1 s) means fewer than half of av seconds of values
    wire [21:0] count_x20 = {2'h0, buffer_count_in, 4'h0} + {4'h0, buffer_count_in, 2'h0};
    reg         next_fault;
    always @* begin
        if (short_avg)
            next_fault = no_value_secs >= `HFC_NO_VALUE_SECS; // R1
        else
            next_fault = count_x20 < {6'h0, averaging_time_setting_in}; // R2
    end
    wire        volt_ok = supply_voltage_in > heating_voltage_threshold_in;
    wire        crit = (fail_secs >= `HFC_CRIT_SECS) && volt_ok; // R6

    always @(posedge sys_clk_in) begin
        if (rst) begin
            no_value_secs <= 8'h0;
            fail_secs     <= 8'h0;
            fault         <= 1'b0;
        end else begin
            if (new_value_in)
                no_value_secs <= 8'h0;
            else if (sec_tick && no_value_secs != 8'hFF)
                no_value_secs <= no_value_secs + 8'h1;
            // continuous failure only; any good period restarts it
            if (!fault)
                fail_secs <= 8'h0;
            else if (sec_tick && fail_secs != 8'hFF)
                fail_secs <= fail_secs + 8'h1; // R6
            fault <= next_fault;
        end
    end

    // heating conditions per mode
    wire [15:0] vt = virtual_temp_in;
    wire [15:0] bt = base_temperature_in;
    // strict compares: a reading equal to a switch point changes nothing
    wire        vt_lt_low  = lt(vt, virtual_temp_low_limit_in);
    wire        vt_gt_low  = lt(virtual_temp_low_limit_in, vt);
    wire        vt_gt_high = lt(virtual_temp_high_limit_in, vt);
    wire        vt_lt_p2   = lt(vt, `HFC_T_P2);
    wire        vt_gt_p2   = lt(`HFC_T_P2, vt);
    wire        vt_gt_p7   = lt(`HFC_T_P7, vt);
    wire        vt_lt_m25  = lt(vt, `HFC_T_M25);
    wire        vt_gt_m20  = lt(`HFC_T_M20, vt);
    wire        bt_lt_p5   = lt(bt, `HFC_T_P5);
    wire        bt_gt_p5   = lt(`HFC_T_P5, bt);
    wire        bt_gt_p8   = lt(`HFC_T_P8, bt);
    wire        bt_lt_p10  = lt(bt, `HFC_T_P10);
    wire        bt_lt_p15  = lt(bt, `HFC_T_P15);
    wire        bt_gt_p15  = lt(`HFC_T_P15, bt);
    wire        bt_lt_p25  = lt(bt, `HFC_T_P25);
    wire        bt_lt_m20  = lt(bt, `HFC_T_M20);
    wire        bt_gt_m15  = lt(`HFC_T_M15, bt);
    wire        bt_gt_m5   = lt(`HFC_T_M5, bt);

    reg  [7:0]  arm_secs;
    reg         arm_on;
    reg         xd_on;
    reg         xd_releasing;
    reg         arm_set;
    reg         arm_clr;
    reg         xd_set;
    reg         xd_rel;
    reg         force_on;

    always @* begin
        arm_set  = 1'b0;
        arm_clr  = 1'b1;
        xd_set   = 1'b0;
        xd_rel   = 1'b1;
        force_on = 1'b0;
        case (heating_mode_select_in)
            `HFC_MODE_VT: begin
                arm_set = vt_lt_low || fault; // R7
                arm_clr = (arm_secs >= `HFC_ARM_MIN_SECS) && vt_gt_high && !crit; // R8
                xd_set  = vt_lt_low || fault; // R7
                xd_rel  = vt_gt_low && !crit; // R9
            end
            `HFC_MODE_RAMP, `HFC_MODE_FULL: begin
                force_on = 1'b1; // R10 R21
            end
            `HFC_MODE_STD: begin
                arm_set = vt_lt_p2 || bt_lt_p5 || (fault && bt_lt_p25); // R11
                arm_clr = vt_gt_p7 && bt_gt_p8 && !crit; // R12
                xd_set  = vt_lt_p2 || bt_lt_p5 || (fault && bt_lt_p10); // R13
                xd_rel  = vt_gt_p2 && bt_gt_p5 && !(crit && bt_lt_p10); // R14
            end
            `HFC_MODE_COLD: begin
                arm_set = vt_lt_p2 || bt_lt_p5 || (crit && bt_lt_p25); // R15
                arm_clr = vt_gt_p7 && bt_gt_p8 && !crit; // R12
                xd_set  = vt_lt_m25 || bt_lt_m20 || (crit && bt_lt_p5); // R16
                xd_rel  = vt_gt_m20 && bt_gt_m15 && !crit; // R17
            end
            `HFC_MODE_HOUSING: begin
                arm_set = vt_lt_p2 || bt_lt_p5 || (crit && bt_lt_p15); // R18
                arm_clr = vt_gt_p7 && bt_gt_p15 && !crit; // R18
                xd_set  = vt_lt_m25 || bt_lt_m20 || (crit && bt_lt_p15); // R19
                xd_rel  = vt_gt_m20 && bt_gt_m5 && !(crit && bt_lt_p15); // R20
            end
            default: begin
                arm_set = 1'b0; // R5
            end
        endcase
    end

    wire hold_done;
    wire hold_run = xd_on && xd_releasing && !xd_set;
    hfc_hold_timer #(.SECS(HOLD_SECS)) u_hold (
        .clk_in   (sys_clk_in),
        .rst_in   (rst),
        .tick_in  (sec_tick),
        .clear_in (force_on || xd_set || !xd_on), // R23
        .run_in   (hold_run),
        .done_out (hold_done)
    );

    always @(posedge sys_clk_in) begin
        if (rst || heat_off(heating_mode_select_in)) begin
            arm_on       <= 1'b0; // R5
            xd_on        <= 1'b0;
            xd_releasing <= 1'b0;
            arm_secs     <= 8'h0;
        end else begin
            if (force_on || arm_set)
                arm_on <= 1'b1;
            else if (arm_clr)
                arm_on <= 1'b0;
            if (!arm_on)
                arm_secs <= 8'h0;
            else if (sec_tick && arm_secs != 8'hFF)
                arm_secs <= arm_secs + 8'h1;
            // release seen once starts the hour; only a fresh switch-on or an off mode cancels it
            if (force_on || xd_set) begin
                xd_on        <= 1'b1;
                xd_releasing <= 1'b0; // R23
            end else if (hold_done) begin
                xd_on        <= 1'b0; // R9
                xd_releasing <= 1'b0;
            end else if (xd_on && xd_rel) begin
                xd_releasing <= 1'b1;
            end
        end
    end

    // output stage: voltage gate, overheat cut and soft start
    wire       arm_eff = arm_on && volt_ok && lt(arm_temp_in, `HFC_T_P30); // R21 R22
    wire       xd_eff  = xd_on && volt_ok; // R21
    reg  [7:0] ramp;
    reg        fault_q;
    // mode 6 skips the soft start and shows the full level at once
    reg  [7:0] next_level;
    always @* begin
        next_level = 8'h0;
        if (arm_eff) begin
            if (heating_mode_select_in == `HFC_MODE_FULL)
                next_level = `HFC_SOFTSTART_SECS; // R21
            else
                next_level = ramp; // R10
        end
    end
    always @(posedge sys_clk_in) begin
        if (rst) begin
            ramp                   <= 8'h0;
            fault_q                <= 1'b0;
            fault_out              <= 1'b0;
            analog_force_out       <= 1'b0;
            analog_force_max_out   <= 1'b0;
            error_telegram_req_out <= 1'b0;
            status_error_out       <= 1'b0;
            criterion_out          <= 1'b0;
            arm_heat_out           <= 1'b0;
            arm_heat_level_out     <= 8'h0;
            transducer_heat_out    <= 1'b0;
            heating_on_out         <= 1'b0;
        end else begin
            fault_q                <= fault;
            fault_out              <= fault;
            analog_force_out       <= fault && analog_enable_in; // R3
            analog_force_max_out   <= error_output_level_select_in; // R3
            error_telegram_req_out <= fault && !fault_q; // R4
            status_error_out       <= fault; // R4
            criterion_out          <= crit;
            // ramp restarts whenever the heater drops out, so a retry is soft too
            if (!arm_eff)
                ramp <= 8'h0;
            else if (sec_tick && ramp < `HFC_SOFTSTART_SECS)
                ramp <= ramp + 8'h1; // R10
            arm_heat_out        <= arm_eff;
            arm_heat_level_out  <= next_level;
            transducer_heat_out <= xd_eff;
            heating_on_out      <= arm_eff || xd_eff;
        end
    end
endmodule
`default_nettype wire

// ==== core/hfc_consts.vh ====
// constants of the heating and fault controller
// temperatures are signed 16-bit in 0.1 degC steps; averaging time in 0.1 s steps
`ifndef HFC_CONSTS_VH
`define HFC_CONSTS_VH
`define HFC_CLK_HZ          50000000
`define HFC_SEC_TICKS       32'd50000000
`define HFC_AVG_10S         16'h0064
`define HFC_NO_VALUE_SECS   8'h0A
`define HFC_CRIT_SECS       8'h0A
`define HFC_ARM_MIN_SECS    8'h0A
`define HFC_SOFTSTART_SECS  8'h7D
`define HFC_HOLD_SECS       12'hE10
`define HFC_T_P2            16'h0014
`define HFC_T_P5            16'h0032
`define HFC_T_P7            16'h0046
`define HFC_T_P8            16'h0050
`define HFC_T_P10           16'h0064
`define HFC_T_P15           16'h0096
`define HFC_T_P25           16'h00FA
`define HFC_T_P30           16'h012C
`define HFC_T_M5            16'hFFCE
`define HFC_T_M15           16'hFF6A
`define HFC_T_M20           16'hFF38
`define HFC_T_M25           16'hFF06
`define HFC_MODE_OFF        3'h0
`define HFC_MODE_VT         3'h1
`define HFC_MODE_RAMP       3'h2
`define HFC_MODE_STD        3'h3
`define HFC_MODE_COLD       3'h4
`define HFC_MODE_HOUSING    3'h5
`define HFC_MODE_FULL       3'h6
`endif

// ==== core/hfc_tick.v ====
// one-second enable pulse divided from the system clock
// assumes a synchronous active-high reset from the top
`timescale 1ns/1ps
`default_nettype none
module hfc_tick #(
    parameter [31:0] DIV = 32'd50000000
) (
    input  wire clk_in,
    input  wire rst_in,
    output reg  tick_out
);
    reg [31:0] count;
    always @(posedge clk_in) begin
        if (rst_in) begin
            count    <= 32'h0;
            tick_out <= 1'b0;
        end else if (count == DIV - 32'd1) begin
            count    <= 32'h0;
            tick_out <= 1'b1;
        end else begin
            count    <= count + 32'd1;
            tick_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ==== core/hfc_hold_timer.v ====
// one-hour style hold timer counted in second ticks
// clear has priority; done is a one-cycle pulse when the count runs out
`timescale 1ns/1ps
`default_nettype none
module hfc_hold_timer #(
    parameter [11:0] SECS = 12'hE10
) (
    input  wire clk_in,
    input  wire rst_in,
    input  wire tick_in,
    input  wire clear_in,
    input  wire run_in,
    output reg  done_out
);
    reg [11:0] secs;
    always @(posedge clk_in) begin
        done_out <= 1'b0;
        if (rst_in || clear_in) begin
            secs <= 12'h0;
        end else if (run_in && tick_in) begin
            if (secs >= SECS - 12'd1) begin
                secs     <= 12'h0;
                done_out <= 1'b1;
            end else begin
                secs <= secs + 12'd1;
            end
        end
    end
endmodule
`default_nettype wire

// ==== verification/hfc_top_properties.sv ====
// checker for the fault and heater outputs of hfc_top
// sees only the top ports; bound into every hfc_top below
`timescale 1ns/1ps
`default_nettype none
module hfc_top_properties #(
    parameter [31:0] SEC_TICKS = 32'd10,
    parameter [11:0] HOLD_SECS = 12'h005
) (
    // clock and reset
    input wire logic        sys_clk_in,
    input wire logic        nrst_in,
    // configuration and measurements
    input wire logic        analog_enable_in,
    input wire logic        error_output_level_select_in,
    input wire logic [2:0]  heating_mode_select_in,
    input wire logic [15:0] heating_voltage_threshold_in,
    input wire logic [15:0] arm_temp_in,
    input wire logic [15:0] supply_voltage_in,
    // outputs watched
    input wire logic        fault_out,
    input wire logic        analog_force_out,
    input wire logic        analog_force_max_out,
    input wire logic        error_telegram_req_out,
    input wire logic        status_error_out,
    input wire logic        criterion_out,
    input wire logic        arm_heat_out,
    input wire logic [7:0]  arm_heat_level_out,
    input wire logic        transducer_heat_out,
    input wire logic        heating_on_out
);
    default clocking cb @(posedge sys_clk_in); endclocking
    default disable iff (!nrst_in);
    property p_force; analog_force_out == (fault_out && $past(analog_enable_in)); endproperty
    a_force: assert property (p_force) else $error("analog force differs from fault");
    property p_max; analog_force_out |-> analog_force_max_out == $past(error_output_level_select_in); endproperty
    a_max: assert property (p_max) else $error("analog level select not followed");
    property p_status; status_error_out == fault_out; endproperty
    a_status: assert property (p_status) else $error("status error differs from fault");
    property p_tlg; error_telegram_req_out == (fault_out && !$past(fault_out)); endproperty
    a_tlg: assert property (p_tlg) else $error("telegram request not on fault onset");
    property p_off; (heating_mode_select_in == 3'h0) [*3] |=> !heating_on_out && !arm_heat_out; endproperty
    a_off: assert property (p_off) else $error("heating on in off mode");
    // criterion needs a long unbroken fault, so fault stood well before its rise
    property p_crit; $rose(criterion_out) |-> fault_out && $past(fault_out, 8); endproperty
    a_crit: assert property (p_crit) else $error("criterion without lasting fault");
    property p_ramp;
        arm_heat_level_out > $past(arm_heat_level_out) && arm_heat_level_out != 8'h7D
            |-> arm_heat_level_out == $past(arm_heat_level_out) + 8'h01;
    endproperty
    a_ramp: assert property (p_ramp) else $error("soft start step not one");
    property p_lvl; !arm_heat_out |-> arm_heat_level_out == 8'h00; endproperty
    a_lvl: assert property (p_lvl) else $error("heat level with arm off");
    property p_volt; (supply_voltage_in <= heating_voltage_threshold_in) [*3] |=> !arm_heat_out; endproperty
    a_volt: assert property (p_volt) else $error("arm heat on at low supply");
    property p_hot; ($signed(arm_temp_in) >= 16'sh012C) [*3] |=> !arm_heat_out; endproperty
    a_hot: assert property (p_hot) else $error("arm heat on when overheated");
endmodule
bind hfc_top hfc_top_properties #(.SEC_TICKS(SEC_TICKS), .HOLD_SECS(HOLD_SECS)) chk_u (
    .sys_clk_in(sys_clk_in), .nrst_in(nrst_in), .analog_enable_in(analog_enable_in),
    .error_output_level_select_in(error_output_level_select_in), .heating_mode_select_in(heating_mode_select_in),
    .heating_voltage_threshold_in(heating_voltage_threshold_in), .arm_temp_in(arm_temp_in),
    .supply_voltage_in(supply_voltage_in), .fault_out(fault_out), .analog_force_out(analog_force_out),
    .analog_force_max_out(analog_force_max_out), .error_telegram_req_out(error_telegram_req_out),
    .status_error_out(status_error_out), .criterion_out(criterion_out), .arm_heat_out(arm_heat_out),
    .arm_heat_level_out(arm_heat_level_out), .transducer_heat_out(transducer_heat_out),
    .heating_on_out(heating_on_out));
`default_nettype wire

// ==== verification/hfc_front_model.sv ====
// measurement front end: one new value per period while running
// assumes the bench clock; dropping run_in is how the bench starves acquisition
`timescale 1ns/1ps
`default_nettype none
module hfc_front_model #(
    parameter integer PERIOD = 10
) (
    input  wire logic clk_in,
    input  wire logic run_in,
    output var logic  new_value_out
);
    integer cnt = 0;
    initial new_value_out = 1'b0;
    always @(posedge clk_in) begin
        cnt <= (cnt >= PERIOD - 1) ? 0 : cnt + 1;
        new_value_out <= run_in && (cnt == 0);
    end
endmodule
`default_nettype wire

// ==== verification/hfc_top_tb.sv ====
// self-checking bench for hfc_top with shortened second and hold counts
// assumes hfc_front_model and the bound checker are compiled alongside
`timescale 1ns/1ps
`default_nettype none
module hfc_top_tb;
    logic        clk = 1'b0, nrst = 1'b0, run = 1'b1, en = 1'b1, sel = 1'b1;
    logic [15:0] thr = 16'h0032;
    logic [2:0]  mode = 3'h0;
    logic [15:0] avg = 16'h0032, cnt = 16'h0000, vt = 16'h00C8, bt = 16'h00C8, at = 16'h0000, sv = 16'h0064;
    wire         nv, flt, frc, fmx, tgr, ste, crit, arm, xdh, hon;
    wire [7:0]   lvl;
    wire [5:0]   obs = {lvl === 8'h7D, hon, xdh, arm, crit, flt};
    integer      err_count = 0, checks_done = 0;
    hfc_front_model #(.PERIOD(10)) fe_u (.clk_in(clk), .run_in(run), .new_value_out(nv));
    hfc_top #(.SEC_TICKS(32'd10), .HOLD_SECS(12'h005)) dut_u (
        .sys_clk_in(clk), .nrst_in(nrst), .new_value_in(nv), .buffer_count_in(cnt),
        .averaging_time_setting_in(avg), .analog_enable_in(en), .error_output_level_select_in(sel),
        .heating_mode_select_in(mode), .virtual_temp_low_limit_in(16'h0000),
        .virtual_temp_high_limit_in(16'h0064), .heating_voltage_threshold_in(thr),
        .virtual_temp_in(vt), .base_temperature_in(bt), .arm_temp_in(at), .supply_voltage_in(sv),
        .fault_out(flt), .analog_force_out(frc), .analog_force_max_out(fmx), .error_telegram_req_out(tgr),
        .status_error_out(ste), .criterion_out(crit), .arm_heat_out(arm), .arm_heat_level_out(lvl),
        .transducer_heat_out(xdh), .heating_on_out(hon));
    initial forever #10 clk = ~clk;
    task automatic step(input integer n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic seen, input logic exp, input string what);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            err_count = err_count + 1;
            $display("unexpected %s: expected %b, seen %b", what, exp, seen);
        end
    endtask
    // bounded wait on one observed output, then compared
    task automatic await(input integer i, input logic v, input integer lim, input string what);
        integer k;
        for (k = 0; k < lim && obs[i] !== v; k++) step(1);
        chk(obs[i], v, what);
    endtask
    task automatic stop_test;
        if (err_count == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    initial begin
        #100000;
        err_count = err_count + 1;
        stop_test();
    end
    initial begin
        step(6);
        nrst = 1'b1;
        step(10);
        chk(flt, 1'b0, "fault idle");
        avg = 16'h00C8;
        cnt = 16'h0009;
        await(0, 1'b1, 5, "fault short buffer");
        cnt = 16'h000A;
        await(0, 1'b0, 5, "fault half buffer");
        avg = 16'h0032;
        run = 1'b0;
        step(75);
        chk(flt, 1'b0, "fault early");
        await(0, 1'b1, 50, "fault no value");
        chk(tgr, 1'b1, "telegram request");
        chk(frc, 1'b1, "analog force");
        chk(fmx, 1'b1, "analog max");
        chk(ste, 1'b1, "status error");
        chk(crit, 1'b0, "criterion early");
        sel = 1'b0;
        step(3);
        chk(fmx, 1'b0, "analog min select");
        chk(frc, 1'b1, "analog force held");
        en = 1'b0;
        step(3);
        chk(frc, 1'b0, "analog disabled");
        await(1, 1'b1, 130, "criterion");
        mode = 3'h1;
        await(2, 1'b1, 5, "mode1 arm");
        chk(xdh, 1'b1, "mode1 transducer");
        run = 1'b1;
        await(0, 1'b0, 20, "fault cleared");
        chk(arm, 1'b1, "arm min on");
        step(20);
        chk(xdh, 1'b1, "transducer hold");
        await(3, 1'b0, 80, "transducer release");
        await(2, 1'b0, 100, "mode1 arm off");
        mode = 3'h2;
        step(1000);
        chk(obs[5], 1'b0, "ramp early");
        await(5, 1'b1, 400, "ramp full");
        mode = 3'h0;
        await(4, 1'b0, 5, "mode0 off");
        mode = 3'h6;
        await(5, 1'b1, 5, "mode6 full");
        thr = 16'h0064;
        await(2, 1'b0, 5, "voltage gate");
        step(4);
        thr = 16'h0032;
        await(2, 1'b1, 5, "voltage restored");
        at = 16'h012C;
        await(2, 1'b0, 5, "overheat");
        step(4);
        at = 16'h012B;
        await(2, 1'b1, 5, "below overheat");
        mode = 3'h3;
        await(2, 1'b0, 5, "mode3 arm off");
        await(3, 1'b0, 60, "mode3 transducer off");
        vt = 16'h0013;
        await(2, 1'b1, 5, "mode3 arm on");
        await(3, 1'b1, 5, "mode3 transducer on");
        vt = 16'h0015;
        step(60);
        chk(arm, 1'b1, "mode3 arm held");
        chk(xdh, 1'b0, "mode3 hold done");
        mode = 3'h4;
        vt = 16'hFEFC;
        await(3, 1'b1, 5, "mode4 transducer on");
        vt = 16'hFF37;
        step(60);
        chk(xdh, 1'b1, "mode4 no release");
        vt = 16'h00C8;
        step(30);
        vt = 16'hFEFC;
        step(3);
        vt = 16'h00C8;
        step(35);
        chk(xdh, 1'b1, "hold restarted");
        await(3, 1'b0, 30, "mode4 hold done");
        bt = 16'h0031;
        await(2, 1'b1, 5, "mode4 arm on");
        bt = 16'h00C8;
        await(2, 1'b0, 5, "mode4 arm off");
        mode = 3'h5;
        vt = 16'hFEFC;
        await(3, 1'b1, 5, "mode5 transducer on");
        chk(arm, 1'b1, "mode5 arm on");
        vt = 16'h0050;
        bt = 16'h0095;
        step(5);
        chk(arm, 1'b1, "mode5 arm held");
        bt = 16'h0097;
        await(2, 1'b0, 5, "mode5 arm off");
        vt = 16'hFEFC;
        step(3);
        vt = 16'hFF39;
        bt = 16'hFFC4;
        step(60);
        chk(xdh, 1'b1, "mode5 no release");
        bt = 16'hFFCF;
        await(3, 1'b0, 60, "mode5 hold done");
        stop_test();
    end
endmodule
`default_nettype wire
